// *** src/core_sfr_map.svh ***
// Offsets, reset values and field positions of the core special-function registers
`ifndef CORE_SFR_MAP_SVH
`define CORE_SFR_MAP_SVH
// ==========================================
// Register offsets in special-function space
`define ADDR_PORT_ZERO_LATCH   8'h80
`define ADDR_STACK_TOP_POINTER 8'h81
`define ADDR_DATA_PTR_LOW_FIRST 8'h82
`define ADDR_DATA_PTR_HIGH_FIRST 8'h83
`define ADDR_DATA_PTR_LOW_AUX  8'h84
`define ADDR_DATA_PTR_HIGH_AUX 8'h85
`define ADDR_POINTER_CHOICE    8'h86
`define ADDR_PORT_ZERO_DRIVE_LOW  8'hac
`define ADDR_PORT_ZERO_DRIVE_HIGH 8'had
// ==========================================
// Reset values
`define RST_PORT_ZERO_LATCH    8'hff
`define RST_STACK_TOP_POINTER  8'h07
`define RST_DATA_PTR           8'h00
`define RST_POINTER_CHOICE     8'h00
`define RST_PORT_ZERO_DRIVE    8'h00
// ==========================================
// Field positions
`define POS_POINTER_SEL        0
`define POS_FLASH_HW_CONFIG_ONE_EXT_BUS       1
`endif

// *** src/core_sfr_pkg.sv ***
// Types shared by the core special-function register bank
package core_sfr_pkg;
	// SFR access from the core
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} sfr_req_s;
	// Stack operation request
	typedef struct packed {
		logic push;
		logic pop;
	} stack_op_s;
	// External memory cycle phase
	typedef enum logic [1:0] {
		EXT_IDLE = 2'b00,
		EXT_ADDR = 2'b01,
		EXT_DATA = 2'b10
	} ext_phase_e;
	// Two-bit drive style of one port pin
	typedef logic [1:0] drive_style_t;
endpackage : core_sfr_pkg

// *** src/port_pin_cell.sv ***
// One pin of the first port: drive selection between I/O and bus use
`timescale 1ns/1ps
module port_pin_cell (
	input  wire logic                       bus_mode,
	input  wire logic                       bus_oe,
	input  wire logic                       bus_bit,
	input  wire logic                       latch_bit,
	input  wire core_sfr_pkg::drive_style_t style,
	output logic                            pin_o,
	output logic                            pin_oe
);
	import core_sfr_pkg::*;
	// Bus use drives address/data; I/O use drives by style
	always_comb begin
		if (bus_mode) begin
			pin_o  = bus_bit;
			pin_oe = bus_oe;
		end else begin
			pin_o = latch_bit;
			case (style)
				2'b00:   pin_oe = ~latch_bit;  // Open drain
				2'b01:   pin_oe = 1'b1;        // Push-pull
				2'b10:   pin_oe = 1'b0;        // Input only
				default: pin_oe = latch_bit;   // Drive high only
			endcase
		end
	end
endmodule : port_pin_cell

// *** src/core_port_stack_pointer_regs.sv ***
// Core SFR bank: first port, stack pointer and data pointers
//
// Contract
// - Port is bus during external cycles, else I/O
// - Address while strobe high, data while low
// - Drive registers pick I/O pin drive style
// - Flash config bit 1 selects bus use
// - Stack pointer increments before push write
// - Stack pointer decrements after pop read
// - Stack pointer resets to 07
// - Low first pointer holds primary low byte
// - Pointer choice register selects active pointer
// - Select 0 first pair, 1 auxiliary pair
// - High first pointer resets to zero
`timescale 1ns/1ps
`include "core_sfr_map.svh"
module core_port_stack_pointer_regs (
	input  wire logic                    clk,
	input  wire logic                    rst_b,
	input  wire core_sfr_pkg::sfr_req_s  sfr_req,
	output logic [7:0]                   sfr_rdata,
	input  wire core_sfr_pkg::stack_op_s stack_op,
	output logic [7:0]                   stack_addr,
	output logic [15:0]                  active_data_pointer,
	input  wire logic [7:0]              flash_hw_config_one,
	input  wire logic                    ext_start,
	input  wire logic                    ext_addr_done,
	input  wire logic                    ext_end,
	input  wire logic                    ext_write,
	input  wire logic [7:0]              ext_addr_low,
	input  wire logic [7:0]              ext_wdata,
	output logic [7:0]                   ext_rdata,
	output logic                         addr_strobe,
	input  wire logic [7:0]              port_pin_i,
	output logic [7:0]                   port_pin_o,
	output logic [7:0]                   port_pin_oe
);
	import core_sfr_pkg::*;

	// ==========================================
	// Register state
	logic [7:0] port_zero_latch_reg, port_zero_latch_next;
	logic [7:0] stack_top_pointer_reg, stack_top_pointer_next;
	logic [7:0] data_ptr_low_first_reg, data_ptr_low_first_next;
	logic [7:0] data_ptr_high_first_reg, data_ptr_high_first_next;
	logic [7:0] data_ptr_low_aux_reg, data_ptr_low_aux_next;
	logic [7:0] data_ptr_high_aux_reg, data_ptr_high_aux_next;
	logic       pointer_choice_reg, pointer_choice_next;
	logic [7:0] port_zero_drive_low_reg, port_zero_drive_low_next;
	logic [7:0] port_zero_drive_high_reg, port_zero_drive_high_next;
	logic [7:0] sfr_rdata_reg, sfr_rdata_next;
	logic [7:0] stack_addr_reg, stack_addr_next;
	ext_phase_e ext_phase_reg, ext_phase_next;
	logic [7:0] bus_byte_reg, bus_byte_next;
	logic [7:0] ext_rdata_reg, ext_rdata_next;
	logic       bus_mode;

	// ==========================================
	// Pin synchroniser: three stages, change once stages two and three agree
	logic [7:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_clean_reg, pin_clean_next;
	always_comb begin
		pin_clean_next = (pin_s2_reg == pin_s3_reg) ? pin_s3_reg : pin_clean_reg;
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_s1_reg    <= 8'hff;
			pin_s2_reg    <= 8'hff;
			pin_s3_reg    <= 8'hff;
			pin_clean_reg <= 8'hff;
		end else begin
			pin_s1_reg    <= port_pin_i;
			pin_s2_reg    <= pin_s1_reg;
			pin_s3_reg    <= pin_s2_reg;
			pin_clean_reg <= pin_clean_next;
		end
	end

	// Bus use chosen by flash configuration, not by a port register
	assign bus_mode = flash_hw_config_one[`POS_FLASH_HW_CONFIG_ONE_EXT_BUS];

	// ==========================================
	// Register writes, stack updates and read mux
	always_comb begin
		port_zero_latch_next      = port_zero_latch_reg;
		stack_top_pointer_next    = stack_top_pointer_reg;
		data_ptr_low_first_next   = data_ptr_low_first_reg;
		data_ptr_high_first_next  = data_ptr_high_first_reg;
		data_ptr_low_aux_next     = data_ptr_low_aux_reg;
		data_ptr_high_aux_next    = data_ptr_high_aux_reg;
		pointer_choice_next       = pointer_choice_reg;
		port_zero_drive_low_next  = port_zero_drive_low_reg;
		port_zero_drive_high_next = port_zero_drive_high_reg;
		stack_addr_next           = stack_addr_reg;
		sfr_rdata_next            = 8'h00;
		if (sfr_req.wr) begin
			if (sfr_req.addr == `ADDR_PORT_ZERO_LATCH) begin
				port_zero_latch_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_STACK_TOP_POINTER) begin
				stack_top_pointer_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_LOW_FIRST) begin
				data_ptr_low_first_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_HIGH_FIRST) begin
				data_ptr_high_first_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_LOW_AUX) begin
				data_ptr_low_aux_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_HIGH_AUX) begin
				data_ptr_high_aux_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_POINTER_CHOICE) begin
				pointer_choice_next = sfr_req.wdata[`POS_POINTER_SEL];
			end else if (sfr_req.addr == `ADDR_PORT_ZERO_DRIVE_LOW) begin
				port_zero_drive_low_next = sfr_req.wdata;
			end else if (sfr_req.addr == `ADDR_PORT_ZERO_DRIVE_HIGH) begin
				port_zero_drive_high_next = sfr_req.wdata;
			end
		end
		// Push: increment first, stack byte goes to new pointer
		if (stack_op.push) begin
			stack_top_pointer_next = stack_top_pointer_reg + 8'h01;
			stack_addr_next        = stack_top_pointer_reg + 8'h01;
		end else if (stack_op.pop) begin
			// Pop: read at current pointer, then decrement
			stack_addr_next        = stack_top_pointer_reg;
			stack_top_pointer_next = stack_top_pointer_reg - 8'h01;
		end
		if (sfr_req.rd) begin
			if (sfr_req.addr == `ADDR_PORT_ZERO_LATCH) begin
				sfr_rdata_next = pin_clean_reg;
			end else if (sfr_req.addr == `ADDR_STACK_TOP_POINTER) begin
				sfr_rdata_next = stack_top_pointer_reg;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_LOW_FIRST) begin
				sfr_rdata_next = data_ptr_low_first_reg;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_HIGH_FIRST) begin
				sfr_rdata_next = data_ptr_high_first_reg;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_LOW_AUX) begin
				sfr_rdata_next = data_ptr_low_aux_reg;
			end else if (sfr_req.addr == `ADDR_DATA_PTR_HIGH_AUX) begin
				sfr_rdata_next = data_ptr_high_aux_reg;
			end else if (sfr_req.addr == `ADDR_POINTER_CHOICE) begin
				sfr_rdata_next = {7'h00, pointer_choice_reg};
			end else if (sfr_req.addr == `ADDR_PORT_ZERO_DRIVE_LOW) begin
				sfr_rdata_next = port_zero_drive_low_reg;
			end else if (sfr_req.addr == `ADDR_PORT_ZERO_DRIVE_HIGH) begin
				sfr_rdata_next = port_zero_drive_high_reg;
			end
		end
	end

	// Register stage for the SFR bank
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			port_zero_latch_reg      <= `RST_PORT_ZERO_LATCH;
			stack_top_pointer_reg    <= `RST_STACK_TOP_POINTER;
			data_ptr_low_first_reg   <= `RST_DATA_PTR;
			data_ptr_high_first_reg  <= `RST_DATA_PTR;
			data_ptr_low_aux_reg     <= `RST_DATA_PTR;
			data_ptr_high_aux_reg    <= `RST_DATA_PTR;
			pointer_choice_reg       <= 1'b0;
			port_zero_drive_low_reg  <= `RST_PORT_ZERO_DRIVE;
			port_zero_drive_high_reg <= `RST_PORT_ZERO_DRIVE;
			sfr_rdata_reg            <= 8'h00;
			stack_addr_reg           <= 8'h00;
		end else begin
			port_zero_latch_reg      <= port_zero_latch_next;
			stack_top_pointer_reg    <= stack_top_pointer_next;
			data_ptr_low_first_reg   <= data_ptr_low_first_next;
			data_ptr_high_first_reg  <= data_ptr_high_first_next;
			data_ptr_low_aux_reg     <= data_ptr_low_aux_next;
			data_ptr_high_aux_reg    <= data_ptr_high_aux_next;
			pointer_choice_reg       <= pointer_choice_next;
			port_zero_drive_low_reg  <= port_zero_drive_low_next;
			port_zero_drive_high_reg <= port_zero_drive_high_next;
			sfr_rdata_reg            <= sfr_rdata_next;
			stack_addr_reg           <= stack_addr_next;
		end
	end

	// Active pointer from the selected pair
	assign active_data_pointer = pointer_choice_reg ?
		{data_ptr_high_aux_reg, data_ptr_low_aux_reg} :
		{data_ptr_high_first_reg, data_ptr_low_first_reg};
	assign sfr_rdata  = sfr_rdata_reg;
	assign stack_addr = stack_addr_reg;

	// ==========================================
	// External memory cycle: address phase then data phase
	always_comb begin
		ext_phase_next = ext_phase_reg;
		bus_byte_next  = bus_byte_reg;
		ext_rdata_next = ext_rdata_reg;
		case (ext_phase_reg)
			EXT_IDLE: begin
				if (ext_start && bus_mode) begin
					ext_phase_next = EXT_ADDR;
					bus_byte_next  = ext_addr_low;
				end
			end
			EXT_ADDR: begin
				if (ext_addr_done) begin
					ext_phase_next = EXT_DATA;
					bus_byte_next  = ext_wdata;
				end
			end
			EXT_DATA: begin
				if (ext_end) begin
					ext_phase_next = EXT_IDLE;
					if (!ext_write) begin
						ext_rdata_next = pin_clean_reg;
					end
				end
			end
			default: ext_phase_next = EXT_IDLE;
		endcase
	end
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ext_phase_reg <= EXT_IDLE;
			bus_byte_reg  <= 8'h00;
			ext_rdata_reg <= 8'h00;
		end else begin
			ext_phase_reg <= ext_phase_next;
			bus_byte_reg  <= bus_byte_next;
			ext_rdata_reg <= ext_rdata_next;
		end
	end
	assign addr_strobe = (ext_phase_reg == EXT_ADDR);
	assign ext_rdata   = ext_rdata_reg;

	// ==========================================
	// Per-pin drive: bus use in external cycles, I/O otherwise
	for (genvar i = 0; i < 8; i++) begin : g_pin
		port_pin_cell u_pin (
			.bus_mode  (bus_mode && (ext_phase_reg != EXT_IDLE)),
			.bus_oe    ((ext_phase_reg == EXT_ADDR) || ext_write),
			.bus_bit   (bus_byte_reg[i]),
			.latch_bit (port_zero_latch_reg[i]),
			.style     ({port_zero_drive_high_reg[i], port_zero_drive_low_reg[i]}),
			.pin_o     (port_pin_o[i]),
			.pin_oe    (port_pin_oe[i])
		);
	end

	// ==========================================
	// Checks
	a_sp_push_inc: assert property (@(posedge clk) disable iff (!rst_b)
		stack_op.push && !sfr_req.wr |=> stack_top_pointer_reg == $past(stack_top_pointer_reg) + 8'h01)
		else $error("push did not increment stack pointer");
	a_sp_pop_dec: assert property (@(posedge clk) disable iff (!rst_b)
		stack_op.pop && !stack_op.push && !sfr_req.wr
		|=> stack_top_pointer_reg == $past(stack_top_pointer_reg) - 8'h01)
		else $error("pop did not decrement stack pointer");
	a_push_addr_new: assert property (@(posedge clk) disable iff (!rst_b)
		stack_op.push |=> stack_addr == stack_top_pointer_reg)
		else $error("push address is not the new pointer");
	a_sp_reset_val: assert property (@(posedge clk)
		!rst_b |=> stack_top_pointer_reg == `RST_STACK_TOP_POINTER)
		else $error("stack pointer reset value wrong");
	a_dph_reset_zero: assert property (@(posedge clk)
		!rst_b |=> data_ptr_high_first_reg == 8'h00 && active_data_pointer == 16'h0000)
		else $error("data pointer reset value wrong");
	// A write into the selected pair shows up on the active pointer next cycle
	a_ptr_sel_aux: assert property (@(posedge clk) disable iff (!rst_b)
		pointer_choice_reg && sfr_req.wr && sfr_req.addr == `ADDR_DATA_PTR_HIGH_AUX
		|=> active_data_pointer[15:8] == $past(sfr_req.wdata))
		else $error("aux pointer not selected");
	a_ptr_sel_first: assert property (@(posedge clk) disable iff (!rst_b)
		!pointer_choice_reg && sfr_req.wr && sfr_req.addr == `ADDR_DATA_PTR_LOW_FIRST
		|=> active_data_pointer[7:0] == $past(sfr_req.wdata))
		else $error("first pointer not selected");
	a_ptr_choice_wr: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == `ADDR_POINTER_CHOICE
		|=> pointer_choice_reg == $past(sfr_req.wdata[`POS_POINTER_SEL]))
		else $error("pointer choice write lost");
	a_strobe_addr: assert property (@(posedge clk) disable iff (!rst_b)
		addr_strobe |-> port_pin_oe == 8'hff && port_pin_o == bus_byte_reg)
		else $error("address not driven while strobe high");
	a_io_no_bus: assert property (@(posedge clk) disable iff (!rst_b)
		!flash_hw_config_one[`POS_FLASH_HW_CONFIG_ONE_EXT_BUS] |=> !addr_strobe)
		else $error("bus cycle started in I/O mode");
	a_dpl_write: assert property (@(posedge clk) disable iff (!rst_b)
		sfr_req.wr && sfr_req.addr == `ADDR_DATA_PTR_LOW_FIRST
		|=> data_ptr_low_first_reg == $past(sfr_req.wdata))
		else $error("low pointer write lost");
endmodule : core_port_stack_pointer_regs

// *** dv/ext_mem_model.sv ***
// External program and data memory on the multiplexed low-address and data bus
`timescale 1ns/1ps
module ext_mem_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       sel,
	input  wire logic       addr_strobe,
	input  wire logic [7:0] pin_level,
	input  wire logic [7:0] bus_oe,
	output logic [7:0]      mem_q,
	output logic            mem_oe
);
	logic [7:0] mem [256];
	logic [7:0] addr_reg;
	logic [7:0] last_reg;
	logic       seen_addr_reg;
	// ==========================================
	// Address latch and write capture
	// Follows the port while the strobe is high, so it holds the byte seen at the fall
	always_ff @(posedge clk) begin
		if (!rst_b || !sel) begin
			seen_addr_reg <= 1'b0;
		end else if (addr_strobe) begin
			seen_addr_reg <= 1'b1;
			addr_reg      <= pin_level;
		end else if (seen_addr_reg && bus_oe == 8'hff) begin
			mem[addr_reg] <= pin_level;
		end
		last_reg <= mem_q;
	end
	// ==========================================
	// Read drive in the data phase; a released bus shows the inverse of the last value
	assign mem_oe = sel && seen_addr_reg && !addr_strobe && bus_oe == 8'h00;
	assign mem_q  = mem_oe ? mem[addr_reg] : ~last_reg;
endmodule : ext_mem_model

// *** dv/core_port_stack_pointer_regs_tb_top.sv ***
// Self-checking bench of the core port, stack pointer and data pointer bank
`timescale 1ns/1ps
module core_port_stack_pointer_regs_tb_top;
	import core_sfr_pkg::*;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	sfr_req_s    sfr_req = '0;
	stack_op_s   stack_op = '0;
	logic [7:0]  cfg = 8'h00;
	logic        ext_start = 1'b0, ext_addr_done = 1'b0, ext_end = 1'b0, ext_write = 1'b0;
	logic [7:0]  ext_addr_low = 8'h00, ext_wdata = 8'h00, io_drive = 8'h5a;
	logic        sel = 1'b0, rd_seen = 1'b0, mem_oe;
	logic [7:0]  sfr_rdata, stack_addr, ext_rdata, port_pin_o, port_pin_oe, pin_level, mem_q;
	logic [15:0] active_data_pointer;
	logic        addr_strobe;
	logic [7:0]  exp_q [$];
	logic [7:0]  p [4];
	logic [7:0]  a, d, lt, eo, ev;
	int          fails = 0, check_count = 0, s, i;
	// ==========================================
	// Clock, pin wire and instances
	always #10 clk = ~clk;
	assign pin_level = (port_pin_oe & port_pin_o) | (~port_pin_oe & (mem_oe ? mem_q : io_drive));
	core_port_stack_pointer_regs core_port_stack_pointer_regs_inst (
		.clk(clk), .rst_b(rst_b), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
		.stack_op(stack_op), .stack_addr(stack_addr),
		.active_data_pointer(active_data_pointer), .flash_hw_config_one(cfg),
		.ext_start(ext_start), .ext_addr_done(ext_addr_done), .ext_end(ext_end),
		.ext_write(ext_write), .ext_addr_low(ext_addr_low), .ext_wdata(ext_wdata),
		.ext_rdata(ext_rdata), .addr_strobe(addr_strobe), .port_pin_i(pin_level),
		.port_pin_o(port_pin_o), .port_pin_oe(port_pin_oe));
	ext_mem_model ext_mem_model_inst (
		.clk(clk), .rst_b(rst_b), .sel(sel), .addr_strobe(addr_strobe),
		.pin_level(pin_level), .bus_oe(port_pin_oe), .mem_q(mem_q), .mem_oe(mem_oe));
	// ==========================================
	// Comparison, closing and bus tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] expd, input string msg);
		check_count++;
		if (seen !== expd) begin
			fails++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, msg, seen, expd);
		end
	endtask : check
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : test_done
	task automatic sfr_wr(input logic [7:0] ad, input logic [7:0] wd);
		@(negedge clk) sfr_req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: wd};
		@(negedge clk) sfr_req <= '0;
	endtask : sfr_wr
	task automatic sfr_rd(input logic [7:0] ad, input logic [7:0] e);
		exp_q.push_back(e);
		@(negedge clk) sfr_req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
		@(negedge clk) sfr_req <= '0;
	endtask : sfr_rd
	task automatic stk(input logic psh);
		@(negedge clk) stack_op <= '{push: psh, pop: ~psh};
		@(negedge clk) stack_op <= '0;
	endtask : stk
	task automatic ext_cycle(input logic wr, input logic [7:0] ad, input logic [7:0] wd,
			input logic bus_on);
		@(negedge clk) begin
			{ext_write, ext_addr_low, ext_wdata, ext_start, sel} <= {wr, ad, wd, 2'b11};
		end
		@(negedge clk) ext_start <= 1'b0;
		check(16'(addr_strobe), 16'(bus_on), "strobe in address phase");
		if (bus_on) check({port_pin_oe, port_pin_o}, {8'hff, ad}, "address on port");
		ext_addr_done <= 1'b1;
		@(negedge clk) ext_addr_done <= 1'b0;
		check(16'(addr_strobe), 16'h0000, "strobe in data phase");
		if (bus_on) check({port_pin_oe, port_pin_o & port_pin_oe},
			wr ? {8'hff, wd} : 16'h0000, "data phase drive");
		repeat (6) @(negedge clk);
		ext_end <= 1'b1;
		@(negedge clk) {ext_end, sel} <= 2'b00;
		@(negedge clk);
	endtask : ext_cycle
	// ==========================================
	// Read result monitor takes the oldest expectation off the queue
	always @(posedge clk) rd_seen <= sfr_req.rd;
	always @(negedge clk) begin
		if (rd_seen === 1'b1) begin
			if (exp_q.size() == 0) check(16'(sfr_rdata), 16'hxxxx, "read with no note");
			else check(16'(sfr_rdata), 16'(exp_q.pop_front()), "register read");
		end
	end
	// ==========================================
	// Watchdog
	initial begin
		#50us;
		fails++;
		test_done();
	end
	// ==========================================
	// Main sequence
	initial begin
		void'($urandom(15));
		repeat (5) @(negedge clk);
		rst_b <= 1'b1;
		repeat (6) @(negedge clk);
		sfr_rd(8'h80, io_drive);
		sfr_rd(8'h81, 8'h07);
		sfr_rd(8'h82, 8'h00);
		sfr_rd(8'h83, 8'h00);
		sfr_rd(8'h86, 8'h00);
		sfr_rd(8'h90, 8'h00);
		check(active_data_pointer, 16'h0000, "pointer after reset");
		// Both pointer pairs through the select bit
		for (s = 0; s < 2; s++) begin
			sfr_wr(8'h86, 8'(s));
			for (i = 0; i < 4; i++) begin
				p[i] = 8'($urandom);
				sfr_wr(8'h82 + 8'(i), p[i]);
			end
			@(negedge clk);
			check(active_data_pointer, s ? {p[3], p[2]} : {p[1], p[0]}, "pointer");
			sfr_rd(8'h82, p[0]);
		end
		// Stack grows before write, shrinks after read, wraps silently
		stk(1'b1);
		check(16'(stack_addr), 16'h0008, "first push address");
		sfr_rd(8'h81, 8'h08);
		stk(1'b0);
		check(16'(stack_addr), 16'h0008, "pop address");
		sfr_rd(8'h81, 8'h07);
		sfr_wr(8'h81, 8'hff);
		stk(1'b1);
		check(16'(stack_addr), 16'h0000, "push wrap");
		stk(1'b0);
		check(16'(stack_addr), 16'h0000, "pop wrap address");
		sfr_rd(8'h81, 8'hff);
		// Each pin drive style
		for (s = 0; s < 4; s++) begin
			lt = 8'($urandom);
			sfr_wr(8'h80, lt);
			sfr_wr(8'hac, {8{s[0]}});
			sfr_wr(8'had, {8{s[1]}});
			@(negedge clk);
			eo = (s == 0) ? ~lt : (s == 1) ? 8'hff : (s == 2) ? 8'h00 : lt;
			ev = (s == 1) ? lt : (s == 3) ? 8'hff : 8'h00;
			check({port_pin_oe, port_pin_o & port_pin_oe}, {eo, ev & eo}, "drive style");
		end
		sfr_wr(8'hac, 8'h00);
		sfr_wr(8'had, 8'h00);
		sfr_wr(8'h80, 8'hff);
		// External cycles: ignored without the bus bit, then write, write, read back
		a = 8'($urandom);
		d = 8'($urandom);
		ext_cycle(1'b1, a, d, 1'b0);
		cfg <= 8'h02;
		ext_cycle(1'b1, a, d, 1'b1);
		ext_cycle(1'b1, a ^ 8'h01, ~d, 1'b1);
		ext_cycle(1'b0, a, 8'h00, 1'b1);
		check(16'(ext_rdata), 16'(d), "external read data");
		// Reset in mid-run brings back the reset values
		rst_b <= 1'b0;
		repeat (2) @(negedge clk);
		rst_b <= 1'b1;
		sfr_rd(8'h81, 8'h07);
		sfr_rd(8'h83, 8'h00);
		@(negedge clk);
		check(active_data_pointer, 16'h0000, "pointer after second reset");
		test_done();
	end
endmodule : core_port_stack_pointer_regs_tb_top
